// *** rtl/cpucd_pkg.sv ***
// Constants, opcodes and states shared by the core datapath
package cpucd_pkg;
  localparam int PC_W = 23;
  localparam int DW = 16;
  localparam int IW = 24;
  localparam int NUM_W = 16;
  localparam int NUM_TRAP = 8;
  localparam int NUM_IRQ = 118;
  localparam int PRIO_W = 3;
  localparam int RPT_W = 14;
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [22:0] RESET_VEC = 23'h00_0000;
  localparam logic [22:0] VEC_BASE = 23'h00_0004;
  localparam logic [22:0] PC_STEP = 23'h00_0002;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] W_STEP = 16'h0002;
  localparam logic [2:0] TRAP_IPL = 3'h7;
  localparam logic [4:0] DIV_FIX = 5'h11;
  localparam logic [4:0] DIV_LAST = 5'h12;
  localparam logic [13:0] DIV_RPT = 14'h0011;
  // Instruction fields (low bit positions)
  localparam int F_OP = 20;
  localparam int F_FN = 18;
  localparam int F_WD = 14;
  localparam int F_WB = 10;
  localparam int F_WS = 6;
  localparam int F_SM = 3;
  localparam int F_DM = 0;
  localparam int F_LWD = 16;
  localparam int F_LIT = 0;
  // Saved status word pushed on exceptions
  localparam int S_RPT = 15;
  localparam int S_DIV = 10;
  localparam int S_IPL = 7;
  localparam int S_PCH = 0;
  localparam logic [2:0] AM_REG = 3'h0;
  localparam logic [2:0] AM_PINC = 3'h2;
  localparam logic [2:0] AM_PDEC = 3'h3;
  localparam logic [2:0] AM_INCP = 3'h4;
  localparam logic [2:0] AM_DECP = 3'h5;
  localparam logic [2:0] AM_OFS = 3'h6;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ALU = 4'h1, OP_MOVL = 4'h2, OP_LDF = 4'h3,
    OP_STF = 4'h4, OP_MUL = 4'h5, OP_DIV = 4'h6, OP_RPT = 4'h7,
    OP_BRA = 4'h8, OP_GOTO = 4'h9, OP_CALL = 4'ha, OP_RET = 4'hb,
    OP_MOVD = 4'hc, OP_TBL = 4'hd, OP_PAGE = 4'he, OP_IPL = 4'hf
  } cpucd_op_e;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000, ST_MOVD = 3'b001, ST_TBL = 3'b010,
    ST_PUSH = 3'b011, ST_POP = 3'b100
  } cpucd_st_e;
endpackage

// *** rtl/cpucd_core.sv ***
// Core datapath: fetch, working registers, multiply, divide, exceptions
// Overview of operation
// - Program counter is 23 bits, stepping by two per instruction word.
// - 16-bit data path, separate program and data ports, 24-bit instructions.
// - Prefetch gives one cycle per instruction except flow changes, MOVD, table.
// - Repeat loops run without overhead and may be interrupted each iteration.
// - Sixteen 16-bit registers usable as data, pointer or offset.
// - Register fifteen is the stack pointer for calls and exceptions.
// - Upper data half maps into program or EEPROM via 8-bit page.
// - One cycle holds memory read, register read, memory write and fetch.
// - 17x17 multiplier: signed, unsigned, mixed, 16x16 or 8x8, one cycle.
// - Non-restoring signed or unsigned 32/16 or 16/16 divide using repeat.
// - Divide takes 19 cycles and survives interrupts between any cycles.
// - Vectored exceptions: eight non-maskable traps, 118 maskable interrupts.
// - Each interrupt has one of seven priorities; highest pending wins.
// - Inherent, relative, literal, direct and seven register modes.
`timescale 1ns/1ps
module cpucd_core (
  input wire logic clk,
  input wire logic rstn,
  output logic [cpucd_pkg::PC_W-1:0] prog_addr,
  input wire logic [cpucd_pkg::IW-1:0] prog_rdata,
  output logic [cpucd_pkg::DW-1:0] dmem_raddr,
  output logic dmem_rd,
  input wire logic [cpucd_pkg::DW-1:0] dmem_rdata,
  output logic [cpucd_pkg::DW-1:0] dmem_waddr,
  output logic [cpucd_pkg::DW-1:0] dmem_wdata,
  output logic dmem_we,
  output logic [cpucd_pkg::PC_W-1:0] win_addr,
  output logic win_rd,
  output logic win_eeprom,
  input wire logic [cpucd_pkg::DW-1:0] win_rdata,
  input wire logic [cpucd_pkg::NUM_TRAP-1:0] trap_req,
  input wire logic [cpucd_pkg::NUM_IRQ-1:0] irq_req,
  input wire logic [cpucd_pkg::NUM_IRQ*cpucd_pkg::PRIO_W-1:0] irq_prio,
  output logic exc_ack,
  output logic [6:0] exc_idx,
  output logic [cpucd_pkg::PC_W-1:0] program_counter,
  output logic [cpucd_pkg::DW-1:0] stack_pointer_register,
  output logic [2:0] cpu_ipl
);
  import cpucd_pkg::*;

  function automatic logic [15:0] ea_f(input logic [2:0] m, input logic [15:0] b,
                                       input logic [15:0] o);
    case (m)
      AM_INCP: ea_f = b + W_STEP;
      AM_DECP: ea_f = b - W_STEP;
      AM_OFS: ea_f = b + o;
      default: ea_f = b;
    endcase
  endfunction

  function automatic logic [15:0] upd_f(input logic [2:0] m, input logic [15:0] b);
    case (m)
      AM_PINC, AM_INCP: upd_f = b + W_STEP;
      AM_PDEC, AM_DECP: upd_f = b - W_STEP;
      default: upd_f = b;
    endcase
  endfunction

  function automatic logic [16:0] ext_f(input logic [15:0] v, input logic s,
                                        input logic byt);
    ext_f = byt ? {{9{s & v[7]}}, v[7:0]} : {s & v[15], v};
  endfunction

  logic [15:0] wreg_r [NUM_W];
  logic [22:0] pc_r, epc_r, push_tgt_r;
  logic [23:0] inst_r;
  logic ivalid_r, win_en_r, win_ee_r, rpt_r, fie_r, exc_ack_r, we_r;
  logic [7:0] page_r;
  logic [2:0] ipl_r;
  logic [13:0] rcount_r;
  logic [4:0] div_cnt_r;
  logic [15:0] div_d_r, tmp_r, push_hi_r, waddr_r, wdata_r;
  logic div_s_r, div_qn_r, div_rn_r;
  logic [6:0] exc_idx_r;
  cpucd_st_e state_r, st_nxt;

  cpucd_op_e op;
  logic [1:0] fn;
  logic [3:0] wd, wb, ws, wl, wd_ev, wd_od;
  logic [2:0] sm, dm;
  logic [15:0] lit, sp, ea_s, ea_d, rd_a, rdata, opb, alu, wdv;
  logic run, exec, take, rpt_hold, rd_en, win_hit;
  assign op = cpucd_op_e'(inst_r[F_OP +: 4]);
  assign fn = inst_r[F_FN +: 2];
  assign wd = inst_r[F_WD +: 4];
  assign wb = inst_r[F_WB +: 4];
  assign ws = inst_r[F_WS +: 4];
  assign wl = inst_r[F_LWD +: 4];
  assign sm = inst_r[F_SM +: 3];
  assign dm = inst_r[F_DM +: 3];
  assign lit = inst_r[F_LIT +: 16];
  assign wd_ev = {wd[3:1], 1'b0};
  assign wd_od = {wd[3:1], 1'b1};
  assign sp = wreg_r[SP_IDX];
  assign wdv = wreg_r[wd];
  assign ea_s = ea_f(sm, wreg_r[ws], wreg_r[wb]);
  assign ea_d = ea_f(dm, wdv, wreg_r[wb]);

  logic [2:0] irq_p, trap_i, exc_ipl;
  logic [6:0] irq_i, exc_nxt;
  logic exc_go;
  always_comb begin
    irq_p = '0;
    irq_i = '0;
    trap_i = '0;
    // highest priority, lowest index on a tie
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req[i] && irq_prio[PRIO_W*i +: PRIO_W] != '0 &&
          irq_prio[PRIO_W*i +: PRIO_W] >= irq_p) begin
        irq_p = irq_prio[PRIO_W*i +: PRIO_W];
        irq_i = 7'(i);
      end
    end
    for (int i = NUM_TRAP - 1; i >= 0; i--) begin
      if (trap_req[i]) begin
        trap_i = 3'(i);
      end
    end
  end
  // Traps ignore the CPU priority and raise it so interrupts stay out
  assign exc_go = (|trap_req) | (irq_p > ipl_r);
  assign exc_nxt = (|trap_req) ? {4'h0, trap_i} : 7'(NUM_TRAP) + irq_i;
  assign exc_ipl = (|trap_req) ? TRAP_IPL : irq_p;
  assign run = state_r == ST_RUN && ivalid_r;
  // exceptions taken at any boundary, also inside a repeat
  assign take = run && exc_go;
  assign exec = run && !exc_go;
  assign rpt_hold = rpt_r && rcount_r != '0;

  // read port, write-behind port and fetch in the same cycle
  assign rd_a = state_r == ST_MOVD ? wreg_r[ws] + W_STEP :
                (state_r == ST_POP || op == OP_RET) ? sp - W_STEP :
                op == OP_LDF ? lit : op == OP_MOVD ? wreg_r[ws] : ea_s;
  assign rd_en = state_r == ST_MOVD || state_r == ST_POP ||
                 (exec && (op == OP_RET || op == OP_LDF || op == OP_MOVD ||
                           (op == OP_ALU && sm != AM_REG)));
  // upper half of data space redirected through the page window
  assign win_hit = win_en_r && rd_a[15];
  assign win_addr = {page_r, rd_a[14:0]};
  assign win_rd = rd_en && win_hit;
  assign win_eeprom = win_ee_r;
  assign dmem_raddr = rd_a;
  assign dmem_rd = rd_en && !win_hit;
  // Forward the pending write so a read right after it sees new data
  assign rdata = win_hit ? win_rdata :
                 (we_r && waddr_r == rd_a) ? wdata_r : dmem_rdata;
  assign opb = sm == AM_REG ? wreg_r[ws] : rdata;
  assign alu = fn == 2'h0 ? wreg_r[wb] + opb : fn == 2'h1 ? wreg_r[wb] - opb :
               fn == 2'h2 ? wreg_r[wb] & opb : wreg_r[wb] | opb;

  // one-cycle 17x17 product; fn picks operand signs, mode bit picks 8x8
  logic signed [33:0] prod;
  assign prod = $signed(ext_f(wreg_r[wb], fn[0], sm[0])) *
                $signed(ext_f(wreg_r[ws], fn[1], sm[0]));

  // non-restoring divide on magnitudes, signs fixed at the end
  logic [15:0] dv_hi, dsr, dsm, d0, d1;
  logic [31:0] dvd, dvm;
  logic [17:0] sh, stp;
  logic dneg, sneg;
  assign dv_hi = fn[1] ? wreg_r[wb | 4'h1] : (fn[0] ? {16{wreg_r[wb][15]}} : '0);
  assign dvd = {dv_hi, wreg_r[wb]};
  assign dneg = fn[0] && dv_hi[15];
  assign dvm = dneg ? -dvd : dvd;
  assign dsr = wreg_r[ws];
  assign sneg = fn[0] && dsr[15];
  assign dsm = sneg ? -dsr : dsr;
  assign sh = {div_s_r, wreg_r[1], wreg_r[0][15]};
  assign stp = div_s_r ? sh + {2'b00, div_d_r} : sh - {2'b00, div_d_r};
  always_comb begin
    d0 = {wreg_r[0][14:0], ~stp[16]};
    d1 = stp[15:0];
    if (div_cnt_r == '0) begin
      d0 = dvm[15:0];
      d1 = dvm[31:16];
    end else if (div_cnt_r == DIV_FIX) begin
      d0 = wreg_r[0];
      d1 = div_s_r ? wreg_r[1] + div_d_r : wreg_r[1];
    end else if (div_cnt_r == DIV_LAST) begin
      d0 = div_qn_r ? -wreg_r[0] : wreg_r[0];
      d1 = div_rn_r ? -wreg_r[1] : wreg_r[1];
    end
  end

  // Sequencing and register write ports (A > B > P > Q on a clash)
  logic a_en, b_en, p_en, q_en, wr_en, adv, flush;
  logic [3:0] a_i, b_i, p_i;
  logic [15:0] a_v, b_v, p_v, q_v, wr_a, wr_d;
  logic [22:0] tgt;
  always_comb begin
    a_en = 1'b0; a_i = wd; a_v = alu;
    b_en = 1'b0; b_i = wd_od; b_v = '0;
    p_en = 1'b0; p_i = ws; p_v = upd_f(sm, wreg_r[ws]);
    q_en = 1'b0; q_v = upd_f(dm, wdv);
    wr_en = 1'b0; wr_a = ea_d; wr_d = alu;
    adv = 1'b0; flush = 1'b0; tgt = pc_r; st_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (!ivalid_r) begin
          adv = 1'b1;
        end else if (take) begin
          // push return address on the stack
          wr_en = 1'b1; wr_a = sp; wr_d = epc_r[15:0];
          p_en = 1'b1; p_i = SP_IDX; p_v = sp + W_STEP;
          st_nxt = ST_PUSH;
        end else begin
          // single-cycle unless flow, MOVD or table
          adv = !rpt_hold;
          case (op)
            OP_ALU: begin
              a_en = dm == AM_REG;
              wr_en = dm != AM_REG;
              p_en = sm inside {AM_PINC, AM_PDEC, AM_INCP, AM_DECP};
              q_en = dm inside {AM_PINC, AM_PDEC, AM_INCP, AM_DECP};
            end
            OP_MOVL: begin
              a_en = 1'b1; a_i = wl; a_v = lit;
            end
            OP_LDF: begin
              a_en = 1'b1; a_i = wl; a_v = rdata;
            end
            OP_STF: begin
              wr_en = 1'b1; wr_a = lit; wr_d = wreg_r[wl];
            end
            OP_MUL: begin
              a_en = 1'b1; a_i = sm[0] ? wd : wd_ev; a_v = prod[15:0];
              b_en = !sm[0]; b_v = prod[31:16];
            end
            OP_DIV: begin
              // nineteen passes, W0 quotient and W1 remainder
              a_en = 1'b1; a_i = 4'h0; a_v = d0;
              b_en = 1'b1; b_i = 4'h1; b_v = d1;
              adv = div_cnt_r != '0 && !rpt_hold;
            end
            OP_BRA: begin
              flush = 1'b1; tgt = pc_r + {{6{lit[15]}}, lit, 1'b0};
            end
            OP_GOTO: begin
              flush = 1'b1; tgt = {2'b00, inst_r[19:0], 1'b0};
            end
            OP_CALL: begin
              wr_en = 1'b1; wr_a = sp; wr_d = pc_r[15:0];
              p_en = 1'b1; p_i = SP_IDX; p_v = sp + W_STEP;
              adv = 1'b0; st_nxt = ST_PUSH;
            end
            OP_RET: begin
              p_en = 1'b1; p_i = SP_IDX; p_v = sp - W_STEP;
              adv = 1'b0; st_nxt = ST_POP;
            end
            OP_MOVD: begin
              a_en = 1'b1; a_i = wd_ev; a_v = rdata;
              adv = 1'b0; st_nxt = ST_MOVD;
            end
            OP_TBL: begin
              adv = 1'b0; st_nxt = ST_TBL;
            end
            default: ;
          endcase
        end
      end
      ST_MOVD: begin
        a_en = 1'b1; a_i = wd_od; a_v = rdata;
        adv = 1'b1; st_nxt = ST_RUN;
      end
      ST_TBL: begin
        // Program port carried the table word, so refetch the next one
        a_en = 1'b1; a_i = wd_ev; a_v = prog_rdata[15:0];
        b_en = 1'b1; b_v = {8'h00, prog_rdata[23:16]};
        flush = 1'b1; st_nxt = ST_RUN;
      end
      ST_PUSH: begin
        wr_en = 1'b1; wr_a = sp; wr_d = push_hi_r;
        p_en = 1'b1; p_i = SP_IDX; p_v = sp + W_STEP;
        flush = 1'b1; tgt = push_tgt_r; st_nxt = ST_RUN;
      end
      ST_POP: begin
        p_en = 1'b1; p_i = SP_IDX; p_v = sp - W_STEP;
        flush = 1'b1; tgt = {tmp_r[S_PCH +: 7], rdata}; st_nxt = ST_RUN;
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // register file, any register as data, pointer or offset
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_W; i++) begin
      if (!rstn) begin
        wreg_r[i] <= (4'(i) == SP_IDX) ? SP_RESET : '0;
      end else if (a_en && a_i == 4'(i)) begin
        wreg_r[i] <= a_v;
      end else if (b_en && b_i == 4'(i)) begin
        wreg_r[i] <= b_v;
      end else if (p_en && p_i == 4'(i)) begin
        wreg_r[i] <= p_v;
      end else if (q_en && wd == 4'(i)) begin
        wreg_r[i] <= q_v;
      end
    end
  end

  // prefetch: the fetched word is executed the following cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_r <= RESET_VEC;
      epc_r <= RESET_VEC;
      inst_r <= '0;
      ivalid_r <= 1'b0;
    end else if (flush) begin
      pc_r <= tgt;
      ivalid_r <= 1'b0;
    end else if (adv) begin
      epc_r <= pc_r;
      inst_r <= prog_rdata;
      pc_r <= pc_r + PC_STEP;
      ivalid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      we_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      we_r <= wr_en;
      waddr_r <= wr_a;
      wdata_r <= wr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= ST_RUN;
      {win_en_r, win_ee_r, rpt_r, fie_r, exc_ack_r} <= '0;
      {page_r, ipl_r, rcount_r, div_cnt_r, exc_idx_r} <= '0;
      {tmp_r, push_hi_r, push_tgt_r} <= '0;
    end else begin
      state_r <= st_nxt;
      exc_ack_r <= take;
      if (take) begin
        // vector by source index; repeat and divide state saved
        exc_idx_r <= exc_nxt;
        ipl_r <= exc_ipl;
        push_hi_r <= {rpt_r, div_cnt_r, ipl_r, epc_r[22:16]};
        push_tgt_r <= VEC_BASE + {14'h0000, exc_nxt, 2'b00};
        rpt_r <= 1'b0;
        div_cnt_r <= '0;
      end else if (state_r == ST_POP && fie_r) begin
        rpt_r <= tmp_r[S_RPT];
        div_cnt_r <= tmp_r[S_DIV +: 5];
        ipl_r <= tmp_r[S_IPL +: 3];
      end else if (exec) begin
        if (rpt_r && op != OP_RPT) begin
          if (rcount_r != '0) begin
            rcount_r <= rcount_r - 14'h0001;
          end else begin
            rpt_r <= 1'b0;
          end
        end
        case (op)
          OP_RPT: begin
            rcount_r <= lit[RPT_W-1:0];
            rpt_r <= 1'b1;
          end
          OP_DIV: begin
            // divide steps ride on the repeat mechanism
            div_cnt_r <= div_cnt_r == DIV_LAST ? 5'h00 : div_cnt_r + 5'h01;
            if (div_cnt_r == '0) begin
              rcount_r <= DIV_RPT;
              rpt_r <= 1'b1;
            end
          end
          OP_PAGE: begin
            page_r <= lit[7:0];
            win_en_r <= lit[8];
            win_ee_r <= lit[9];
          end
          OP_IPL: ipl_r <= lit[2:0];
          OP_CALL: begin
            push_hi_r <= {9'h000, pc_r[22:16]};
            push_tgt_r <= {2'b00, inst_r[19:0], 1'b0};
          end
          OP_RET: begin
            tmp_r <= rdata;
            fie_r <= fn[0];
          end
          default: ;
        endcase
      end
    end
  end

  // divide working state kept between passes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {div_d_r, div_s_r, div_qn_r, div_rn_r} <= '0;
    end else if (exec && op == OP_DIV) begin
      if (div_cnt_r == '0) begin
        div_d_r <= dsm;
        div_s_r <= 1'b0;
        div_qn_r <= dneg ^ sneg;
        div_rn_r <= dneg;
      end else if (div_cnt_r < DIV_FIX) begin
        div_s_r <= stp[16];
      end else begin
        div_s_r <= 1'b0;
      end
    end
  end

  // program port carries table reads in their second cycle
  assign prog_addr = state_r == ST_TBL ? {page_r[6:0], wreg_r[ws]} : pc_r;
  assign dmem_waddr = waddr_r;
  assign dmem_wdata = wdata_r;
  assign dmem_we = we_r;
  assign exc_ack = exc_ack_r;
  assign exc_idx = exc_idx_r;
  assign program_counter = pc_r;
  assign stack_pointer_register = sp;
  assign cpu_ipl = ipl_r;
endmodule

// *** dv/cpucd_monitor.sv ***
// Port assertions for the core datapath
`timescale 1ns/1ps
module cpucd_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [cpucd_pkg::DW-1:0] dmem_waddr,
  input wire logic dmem_we,
  input wire logic win_rd,
  input wire logic win_eeprom,
  input wire logic [cpucd_pkg::NUM_TRAP-1:0] trap_req,
  input wire logic [cpucd_pkg::NUM_IRQ*cpucd_pkg::PRIO_W-1:0] irq_prio,
  input wire logic exc_ack,
  input wire logic [6:0] exc_idx,
  input wire logic [cpucd_pkg::PC_W-1:0] program_counter,
  input wire logic [cpucd_pkg::DW-1:0] stack_pointer_register,
  input wire logic [2:0] cpu_ipl
);
  import cpucd_pkg::*;
  logic [8:0] pos;
  logic [2:0] src_prio;
  logic is_irq;
  assign is_irq = exc_ack && exc_idx >= 7'h08;
  // Index is only meaningful for interrupt entries, so every use is guarded by is_irq
  assign pos = 9'(exc_idx - 7'h08) * 9'h003;
  assign src_prio = irq_prio[pos +: 3];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_state: assert property (disable iff (1'b0) !rstn |=> program_counter == RESET_VEC
    && stack_pointer_register == SP_RESET && cpu_ipl == 3'h0 && !dmem_we && !exc_ack)
    else $error("state not cleared by reset");
  a_counter_even: assert property (program_counter[0] == 1'b0)
    else $error("fetch address odd");
  a_ack_pulse: assert property (exc_ack |=> !exc_ack)
    else $error("exception acknowledge longer than one cycle");
  a_trap_ipl: assert property (exc_ack && exc_idx < 7'h08 |-> ##[0:2] cpu_ipl == TRAP_IPL)
    else $error("trap did not raise level");
  a_irq_level: assert property (is_irq |-> src_prio != 3'h0 ##[0:2] cpu_ipl == src_prio)
    else $error("interrupt level mismatch");
  a_vector_jump: assert property (exc_ack |-> ##[1:2]
    program_counter == VEC_BASE + {14'h0, exc_idx, 2'h0})
    else $error("vector address wrong");
  a_push_pair: assert property ($rose(exc_ack) |-> ##[0:1] dmem_we
    ##1 (dmem_we && dmem_waddr == $past(dmem_waddr) + W_STEP))
    else $error("context push not two words upward");
  a_stack_step: assert property (exc_ack |=>
    stack_pointer_register == $past(stack_pointer_register) + W_STEP)
    else $error("stack pointer step wrong");
  a_trap_taken: assert property ($rose(|trap_req) |-> ##[1:30] (exc_ack && exc_idx < 7'h08))
    else $error("trap not taken in time");
  c_trap: cover property (exc_ack && exc_idx < 7'h08);
  c_irq: cover property (is_irq);
  c_eeprom: cover property (win_rd && win_eeprom);
endmodule
bind cpucd_core cpucd_monitor cpucd_monitor_inst (.clk, .rstn, .dmem_waddr, .dmem_we, .win_rd,
  .win_eeprom, .trap_req, .irq_prio, .exc_ack, .exc_idx, .program_counter,
  .stack_pointer_register, .cpu_ipl);

// *** dv/cpucd_mem.sv ***
// Behavioural program, data and EEPROM memories facing the core
`timescale 1ns/1ps
module cpucd_mem (
  input wire logic clk,
  input wire logic [cpucd_pkg::PC_W-1:0] prog_addr,
  output logic [cpucd_pkg::IW-1:0] prog_rdata,
  input wire logic [cpucd_pkg::DW-1:0] dmem_raddr,
  input wire logic dmem_rd,
  output logic [cpucd_pkg::DW-1:0] dmem_rdata,
  input wire logic [cpucd_pkg::DW-1:0] dmem_waddr,
  input wire logic [cpucd_pkg::DW-1:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic [cpucd_pkg::PC_W-1:0] win_addr,
  input wire logic win_rd,
  input wire logic win_eeprom,
  output logic [cpucd_pkg::DW-1:0] win_rdata
);
  import cpucd_pkg::*;
  logic [23:0] pmem [0:255];
  logic [15:0] dmem [0:2047];
  logic [22:0] win_seen;
  logic [15:0] win_word;
  assign prog_rdata = pmem[prog_addr[8:1]];
  // Unstrobed reads return inverted data so a stale value never passes
  assign dmem_rdata = dmem_rd ? dmem[dmem_raddr[11:1]] : ~dmem[dmem_raddr[11:1]];
  assign win_word = win_addr[15:0] ^ (win_eeprom ? 16'ha5a5 : 16'h5a5a);
  assign win_rdata = win_rd ? win_word : ~win_word;
  always @(posedge clk) begin
    if (dmem_we) begin
      dmem[dmem_waddr[11:1]] <= dmem_wdata;
    end
    if (win_rd) begin
      win_seen <= win_addr;
    end
  end
endmodule

// *** dv/cpu_core_datapath_tb.sv ***
// Self-checking bench for the core datapath
`timescale 1ns/1ps
module cpu_core_datapath_tb;
  import cpucd_pkg::*;
  logic clk, rstn, dmem_rd, dmem_we, win_rd, win_eeprom, exc_ack;
  logic [PC_W-1:0] prog_addr, win_addr, program_counter;
  logic [IW-1:0] prog_rdata;
  logic [DW-1:0] dmem_raddr, dmem_rdata, dmem_waddr, dmem_wdata, win_rdata;
  logic [DW-1:0] stack_pointer_register;
  logic [NUM_TRAP-1:0] trap_req;
  logic [NUM_IRQ-1:0] irq_req;
  logic [NUM_IRQ*PRIO_W-1:0] irq_prio;
  logic [6:0] exc_idx;
  logic [2:0] cpu_ipl;
  int failures, n_checks, wp;
  cpucd_core cpucd_core_inst (.clk, .rstn, .prog_addr, .prog_rdata, .dmem_raddr, .dmem_rd,
    .dmem_rdata, .dmem_waddr, .dmem_wdata, .dmem_we, .win_addr, .win_rd, .win_eeprom,
    .win_rdata, .trap_req, .irq_req, .irq_prio, .exc_ack, .exc_idx, .program_counter,
    .stack_pointer_register, .cpu_ipl);
  cpucd_mem cpucd_mem_inst (.clk, .prog_addr, .prog_rdata, .dmem_raddr, .dmem_rd, .dmem_rdata,
    .dmem_waddr, .dmem_wdata, .dmem_we, .win_addr, .win_rd, .win_eeprom, .win_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic mchk(input string what, input logic [15:0] a, input logic [15:0] exp);
    chk(what, exp, cpucd_mem_inst.dmem[a[11:1]]);
  endtask
  function automatic logic [23:0] li(input logic [3:0] op, wd, input logic [15:0] lit);
    return {op, wd, lit};
  endfunction
  function automatic logic [23:0] ri(input logic [3:0] op, input logic [1:0] fn,
      input logic [3:0] wd, wb, ws, input logic [2:0] sm);
    return {op, fn, wd, wb, ws, sm, 3'h0};
  endfunction
  task automatic put(input logic [23:0] w);
    cpucd_mem_inst.pmem[wp] = w;
    wp++;
  endtask
  // Holds the core in reset while a new program is loaded
  task automatic start;
    @(negedge clk);
    rstn = 1'b0;
    for (int i = 0; i < 256; i++) cpucd_mem_inst.pmem[i] = 24'h00_0000;
    wp = 0;
  endtask
  // Ends the program with a marker store and waits for it
  task automatic run;
    int n;
    put(li(OP_STF, 4'h0, 16'h0ffe));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    n = 0;
    while (!(dmem_we === 1'b1 && dmem_waddr === 16'h0ffe) && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic wait_ack;
    int n;
    n = 0;
    while (exc_ack !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic t_reset;
    start();
    repeat (2) @(negedge clk);
    chk("counter", RESET_VEC, program_counter); // cleared
    chk("stack", SP_RESET, stack_pointer_register); // stack start
    chk("level", 0, cpu_ipl); // level
    chk("write", 0, dmem_we); // quiet
  endtask
  task automatic t_alu;
    logic [15:0] e [7] = '{16'h2143, 16'h0325, 16'h0204, 16'h1f3f, 16'h0202, 16'h1245, 16'h1256};
    start();
    cpucd_mem_inst.dmem[16'h0100] = 16'h0011;
    cpucd_mem_inst.dmem[16'h0101] = 16'h0022;
    put(li(OP_MOVL, 4'h1, 16'h1234));
    put(li(OP_MOVL, 4'h2, 16'h0f0f));
    put(li(OP_MOVL, 4'h7, 16'h0200));
    for (int f = 0; f < 4; f++) put(ri(OP_ALU, 2'(f), 4'(3 + f), 4'h1, 4'h2, AM_REG));
    put(ri(OP_ALU, 2'h0, 4'h8, 4'h1, 4'h7, AM_PINC));
    put(ri(OP_ALU, 2'h0, 4'h9, 4'h1, 4'h7, 3'h1));
    for (int r = 3; r < 10; r++) put(li(OP_STF, 4'(r), 16'(16'h0100 + 2 * r)));
    run();
    for (int r = 3; r < 10; r++) mchk("alu", 16'(16'h0100 + 2 * r), e[r-3]); // add, sub, and, or, post-increment pointer
  endtask
  task automatic t_mul;
    logic [15:0] e [6] = '{16'h02d0, 16'hffd0, 16'h02d0, 16'hffd0, 16'h8000, 16'hfffe};
    start();
    put(li(OP_MOVL, 4'h1, 16'h00f0));
    put(li(OP_MOVL, 4'h2, 16'h0003));
    put(li(OP_MOVL, 4'ha, 16'h8000));
    // Mode bit set selects 8x8 into one register
    for (int f = 0; f < 4; f++) put(ri(OP_MUL, 2'(f), 4'(3 + f), 4'h1, 4'h2, 3'h1));
    put(ri(OP_MUL, 2'h3, 4'hc, 4'ha, 4'h2, AM_REG));
    for (int f = 0; f < 6; f++) put(li(OP_STF, 4'(3 + f + (f / 4) * 5), 16'(16'h0100 + 2 * f)));
    run();
    for (int f = 0; f < 6; f++) mchk("mul", 16'(16'h0100 + 2 * f), e[f]); // products
  endtask
  task automatic t_div;
    logic [15:0] e [6] = '{16'h000e, 16'h0002, 16'hfff2, 16'hfffe, 16'h2492, 16'h0002};
    start();
    put(li(OP_MOVL, 4'h2, 16'h0064));
    put(li(OP_MOVL, 4'h3, 16'h0007));
    put(li(OP_MOVL, 4'h4, 16'h0000));
    put(li(OP_MOVL, 4'h5, 16'h0001));
    for (int k = 0; k < 3; k++) begin
      if (k == 1) put(li(OP_MOVL, 4'h2, 16'hff9c));
      put(ri(OP_DIV, k == 1 ? 2'h1 : 2'(k), 4'h0, k == 2 ? 4'h4 : 4'h2, 4'h3, AM_REG));
      put(li(OP_STF, 4'h0, 16'(16'h0100 + 4 * k)));
      put(li(OP_STF, 4'h1, 16'(16'h0102 + 4 * k)));
    end
    run();
    for (int k = 0; k < 6; k++) mchk("div", 16'(16'h0100 + 2 * k), e[k]); // results
  endtask
  task automatic t_rpt;
    start();
    put(li(OP_MOVL, 4'h1, 16'h0000));
    put(li(OP_MOVL, 4'h2, 16'h0001));
    put(li(OP_RPT, 4'h0, 16'h0003));
    put(ri(OP_ALU, 2'h0, 4'h1, 4'h1, 4'h2, AM_REG));
    put(li(OP_STF, 4'h1, 16'h0100));
    run();
    mchk("repeat", 16'h0100, 16'h0004); // count
  endtask
  task automatic t_flow;
    start();
    put(li(OP_MOVL, 4'h1, 16'h0011));
    put(li(OP_CALL, 4'h0, 16'h0006));
    put(li(OP_STF, 4'h2, 16'h0100));
    put(li(OP_BRA, 4'h0, 16'h0001));
    put(li(OP_MOVL, 4'h1, 16'hbad0));
    put(li(OP_GOTO, 4'h0, 16'h0008));
    put(li(OP_MOVL, 4'h2, 16'h0022));
    put(li(OP_RET, 4'h0, 16'h0000));
    put(li(OP_STF, 4'h1, 16'h0102));
    put(li(OP_MOVL, 4'h4, 16'h0100));
    put(ri(OP_MOVD, 2'h0, 4'h6, 4'h0, 4'h4, AM_REG));
    put(ri(OP_TBL, 2'h0, 4'h8, 4'h0, 4'h3, AM_REG));
    put(li(OP_IPL, 4'h0, 16'h0003));
    put(li(OP_STF, 4'h7, 16'h0104));
    put(li(OP_STF, 4'h9, 16'h0106));
    run();
    mchk("call", 16'h0100, 16'h0022); // call and return
    mchk("branch", 16'h0102, 16'h0011); // branch and jump
    mchk("movd", 16'h0104, 16'h0011); // double move
    mchk("table", 16'h0106, 16'h0021); // table read
    chk("setipl", 3, cpu_ipl); // level set
  endtask
  task automatic t_win;
    start();
    put(li(OP_PAGE, 4'h0, 16'h0105));
    put(li(OP_LDF, 4'h3, 16'h8004));
    put(li(OP_STF, 4'h3, 16'h0100));
    put(li(OP_PAGE, 4'h0, 16'h0305));
    put(li(OP_LDF, 4'h4, 16'h8004));
    put(li(OP_STF, 4'h4, 16'h0102));
    run();
    mchk("window", 16'h0100, 16'hda5e); // program side
    mchk("eeprom", 16'h0102, 16'h25a1); // eeprom side
    chk("page", 23'h02_8004, cpucd_mem_inst.win_seen); // page
  endtask
  task automatic t_exc;
    start();
    irq_prio[12 +: 3] = 3'h3;
    irq_prio[30 +: 3] = 3'h5;
    irq_prio[60 +: 3] = 3'h2;
    run();
    irq_req[4] = 1'b1;
    irq_req[10] = 1'b1;
    wait_ack();
    chk("index", 18, exc_idx); // arbitration
    irq_req = '0;
    repeat (3) @(negedge clk);
    chk("level", 5, cpu_ipl); // level
    chk("stack", 16'h0804, stack_pointer_register); // push
    irq_req[20] = 1'b1;
    repeat (10) begin
      @(negedge clk);
      chk("masked", 0, exc_ack); // lower level
    end
    trap_req = 8'h24;
    wait_ack();
    chk("trap", 2, exc_idx); // lowest trap
    trap_req = '0;
    irq_req = '0;
    repeat (3) @(negedge clk);
    chk("level", 7, cpu_ipl); // trap level
    chk("stack", 16'h0808, stack_pointer_register); // push
  endtask
  initial begin
    rstn = 1'b0;
    trap_req = '0;
    irq_req = '0;
    irq_prio = '0;
    failures = 0;
    n_checks = 0;
    t_reset();
    t_alu();
    t_mul();
    t_div();
    t_rpt();
    t_flow();
    t_win();
    t_exc();
    wrap_up();
  end
endmodule
